// ==== hw/prom_programmer.sv ====
`timescale 1ns/1ps
module prom_programmer
   import prom_prog_pkg::*;
(
   input  wire logic              SYS_CLK,
   input  wire logic              RST_N,
   input  wire logic              START_PAGE,
   input  wire logic              START_BYTE,
   input  wire logic              START_READ,
   input  wire logic [ADDR_W-1:0] REQ_ADDR,
   input  wire logic [31:0]       REQ_DATA,
   output logic                   BUSY,
   output logic                   DONE,
   output logic                   FAIL,
   output logic                   RANGE_ERR,
   output logic [DATA_W-1:0]      READ_DATA,
   output logic [3:0]             TRIES,
   output logic                   TARGET_RESET_N,
   output prom_prog_pkg::supply_t SUPPLY_SEL,
   output logic [ADDR_W-1:0]      ADDRESS_BUS,
   output logic                   CHIP_SELECT_N,
   output logic                   OUTPUT_GATE_N,
   output logic                   PROGRAM_PULSE_N,
   output logic [DATA_W-1:0]      DATA_BUS_O,
   output logic                   DATA_BUS_OE,
   input  wire logic [DATA_W-1:0] DATA_BUS_I
);
   import prom_prog_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE   = 4'b0000,
      S_LATCH  = 4'b0001,
      S_SETUP  = 4'b0010,
      S_PULSE  = 4'b0011,
      S_VSET   = 4'b0100,
      S_VSAMP  = 4'b0101,
      S_DONE   = 4'b0110,
      S_RSET   = 4'b0111,
      S_RSAMP  = 4'b1000,
      S_LSTB   = 4'b1001
   } state_t;

   state_t            state;
   state_t            next_state;
   logic              page_mode;
   logic [ADDR_W-1:0] base;
   logic [31:0]       wdata;
   logic [1:0]        idx;
   logic [3:0]        tries;
   logic              mismatch;
   logic              t_start;
   logic [11:0]       t_len;
   logic              t_busy;
   logic              t_done;

   wire [ADDR_W-1:0] span_end = base + ADDR_W'(page_mode ? PAGE_BYTES - 1 : 0);
   // Page end is checked by lowering the limit, so a top address cannot wrap to zero
   wire in_range = (REQ_ADDR >= ADDR_FIRST) &&
      (REQ_ADDR <= ADDR_LAST - ADDR_W'(START_PAGE ? PAGE_BYTES - 1 : 0));
   wire req_any = START_PAGE || START_BYTE || START_READ;
   wire [DATA_W-1:0] cur_byte = wdata[DATA_W*idx +: DATA_W];
   wire byte_bad = (DATA_BUS_I != cur_byte);
   wire last_idx = !page_mode || (idx == 2'(PAGE_BYTES - 1));
   wire verify_bad = mismatch || byte_bad;
   wire give_up = verify_bad && (tries >= MAX_TRIES);

   pulse_timer u_timer (
      .clk    (SYS_CLK),
      .rst_n  (RST_N),
      .start  (t_start),
      .length (t_len),
      .busy   (t_busy),
      .done   (t_done)
   );

   always_comb
   begin
      next_state = state;
      t_start = 1'b0;
      t_len = SETTLE_CNT;
      unique case (state)
         S_IDLE:
            if (req_any && in_range)
            begin
               t_start = 1'b1;
               next_state = START_READ ? S_RSET : (START_PAGE ? S_LATCH : S_SETUP);
            end
         S_LATCH:
            if (t_done)
            begin
               t_start = 1'b1;
               next_state = S_LSTB;
            end
         S_LSTB:
            if (t_done)
            begin
               t_start = 1'b1;
               next_state = last_idx ? S_SETUP : S_LATCH;
            end
         S_SETUP:
            if (t_done)
            begin
               t_start = 1'b1;
               t_len = PULSE_CNT;
               next_state = S_PULSE;
            end
         S_PULSE:
            if (t_done)
            begin
               t_start = 1'b1;
               next_state = S_VSET;
            end
         S_VSET:
            if (t_done)
               next_state = S_VSAMP;
         S_VSAMP:
            if (!last_idx)
            begin
               t_start = 1'b1;
               next_state = S_VSET;
            end
            else if (!verify_bad || give_up)
               next_state = S_DONE;
            else
            begin
               t_start = 1'b1;
               next_state = page_mode ? S_LATCH : S_SETUP;
            end
         S_RSET:
            if (t_done)
               next_state = S_RSAMP;
         S_RSAMP:
            next_state = S_DONE;
         S_DONE:
            next_state = S_IDLE;
         default:
            next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         page_mode <= 1'b0;
         base <= '0;
         wdata <= {4{ERASED_BYTE}};
         idx <= 2'b00;
         tries <= 4'h0;
         mismatch <= 1'b0;
         FAIL <= 1'b0;
         RANGE_ERR <= 1'b0;
         READ_DATA <= 8'h00;
      end
      else
      begin
         if (state == S_IDLE && req_any)
         begin
            page_mode <= START_PAGE;
            base <= REQ_ADDR;
            wdata <= START_PAGE ? REQ_DATA : {24'h000000, REQ_DATA[7:0]};
            idx <= 2'b00;
            tries <= 4'h0;
            mismatch <= 1'b0;
            FAIL <= 1'b0;
            RANGE_ERR <= !in_range;
         end
         if (state == S_LSTB && t_done)
            idx <= last_idx ? 2'b00 : idx + 2'b01;
         if (state == S_PULSE && t_done)
            tries <= tries + 4'h1;
         if (state == S_VSAMP)
         begin
            mismatch <= last_idx ? 1'b0 : verify_bad;
            idx <= last_idx ? 2'b00 : idx + 2'b01;
            FAIL <= last_idx && give_up;
         end
         if (state == S_RSAMP)
            READ_DATA <= DATA_BUS_I;
      end
   end

   // Device reset stays low for the whole session, so no mode is left by accident
   wire session = (state != S_IDLE) && (state != S_DONE);
   wire latching = (state == S_LATCH) || (state == S_LSTB);
   wire writing = (state == S_SETUP) || (state == S_PULSE);
   wire reading = (state == S_VSET) || (state == S_VSAMP) ||
      (state == S_RSET) || (state == S_RSAMP);

   assign TARGET_RESET_N = 1'b0;
   assign SUPPLY_SEL = (state == S_RSET || state == S_RSAMP) ? SUPPLY_READ :
      (session ? SUPPLY_PROG : SUPPLY_OFF);
   assign ADDRESS_BUS = (page_mode && !writing) ? span_end - ADDR_W'(PAGE_BYTES - 1)
      + ADDR_W'(idx) : base;
   // Page latch: select high, gate low; page pulse: both high; byte: select low
   assign CHIP_SELECT_N = !(reading || (writing && !page_mode));
   assign OUTPUT_GATE_N = !(reading || latching);
   // Idle holds the pulse high so a shared, unselected part never writes
   assign PROGRAM_PULSE_N = !(state == S_PULSE && t_busy);
   assign DATA_BUS_O = cur_byte;
   assign DATA_BUS_OE = latching || (writing && !page_mode);
   assign BUSY = (state != S_IDLE);
   assign DONE = (state == S_DONE);
   assign TRIES = tries;
   // Erased cells read back as all ones, so a fresh part verifies against that

   // A repetition only sees the first cycles; this counter covers the whole pulse
   logic [11:0] low_cnt;
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
         low_cnt <= 12'h000;
      else
         low_cnt <= PROGRAM_PULSE_N ? 12'h000 : low_cnt + 12'h001;
   end

   AST_RESET_LOW: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      TARGET_RESET_N == 1'b0) else $error("target reset released");
   AST_READ_GATE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (state == S_RSAMP) |-> (!CHIP_SELECT_N && !OUTPUT_GATE_N && PROGRAM_PULSE_N))
      else $error("read mode pins wrong");
   AST_NO_CLASH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      DATA_BUS_OE |-> (CHIP_SELECT_N || OUTPUT_GATE_N))
      else $error("driving while device may drive");
   AST_STANDBY: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (state == S_IDLE) |-> (CHIP_SELECT_N && !DATA_BUS_OE))
      else $error("idle not standby");
   AST_LATCH: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (state == S_LATCH) |-> (CHIP_SELECT_N && !OUTPUT_GATE_N && PROGRAM_PULSE_N))
      else $error("latch pins wrong");
   sequence pulse_start;
      $fell(PROGRAM_PULSE_N);
   endsequence
   AST_PULSE_PAGE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      pulse_start |-> (CHIP_SELECT_N == page_mode) && OUTPUT_GATE_N)
      else $error("pulse mode pins wrong");
   AST_PULSE_LEN: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      pulse_start |-> !PROGRAM_PULSE_N [*8]) else $error("pulse too short");
   AST_PULSE_FULL: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      $rose(PROGRAM_PULSE_N) |-> low_cnt == PULSE_CNT) else $error("pulse width wrong");
   AST_TRIES: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      tries <= MAX_TRIES) else $error("too many attempts");
   AST_FAIL: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      $rose(FAIL) |-> tries == MAX_TRIES) else $error("fail before last try");
endmodule

// ==== hw/prom_prog_pkg.sv ====
package prom_prog_pkg;
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PAGE_BYTES = 4;
   localparam logic [ADDR_W-1:0] ADDR_FIRST = 17'h00000;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 17'h0efff;
   localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
   localparam logic [3:0] MAX_TRIES = 4'ha;
   localparam int CLK_NS = 100;
   localparam int PULSE_NS = 100000;
   localparam int PULSE_CYC = PULSE_NS / CLK_NS;
   localparam int SETTLE_CYC = 2;
   localparam logic [11:0] PULSE_CNT = 12'(PULSE_CYC);
   localparam logic [11:0] SETTLE_CNT = 12'(SETTLE_CYC);
   typedef enum logic [1:0] {
      SUPPLY_OFF   = 2'b00,
      SUPPLY_READ  = 2'b01,
      SUPPLY_PROG  = 2'b10
   } supply_t;
endpackage

// ==== hw/pulse_timer.sv ====
`timescale 1ns/1ps
module pulse_timer
   import prom_prog_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        start,
   input  wire logic [11:0] length,
   output logic             busy,
   output logic             done
);
   logic [11:0] count;
   wire         last = busy && (count == 12'h001);
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count <= 12'h000;
         busy <= 1'b0;
      end
      else if (start)
      begin
         count <= length;
         busy <= 1'b1;
      end
      else if (busy)
      begin
         count <= count - 12'h001;
         busy <= !last;
      end
   end
   assign done = last;
endmodule

// ==== test/prom_device_model.sv ====
`timescale 1ns/1ps
module prom_device_model
(
   input  wire logic                             clk,
   input  wire logic                             reset_n,
   input  wire prom_prog_pkg::supply_t           supply,
   input  wire logic [prom_prog_pkg::ADDR_W-1:0] address_bus,
   input  wire logic                             chip_select_n,
   input  wire logic                             output_gate_n,
   input  wire logic                             program_pulse_n,
   input  wire logic [prom_prog_pkg::DATA_W-1:0] host_d,
   input  wire logic                             host_oe,
   input  wire logic [4:0]                       need,
   input  wire logic                             clear,
   output logic [prom_prog_pkg::DATA_W-1:0]      data_bus
);
   import prom_prog_pkg::*;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] page [PAGE_BYTES];
   logic [ADDR_W-1:0] page_base;
   logic [DATA_W-1:0] last = '0;
   int                low_cyc = 0;
   int                hits = 0;
   wire               prog_ok = !reset_n && supply == SUPPLY_PROG;
   wire               drive = !reset_n && supply != SUPPLY_OFF && !chip_select_n
                              && !output_gate_n && program_pulse_n;
   wire               fire = prog_ok && output_gate_n && low_cyc == PULSE_CYC - 1
                             && !program_pulse_n && hits + 1 >= need;
   // A floating bus shows a changing pattern, the inverse of the byte seen one cycle before
   assign data_bus = host_oe ? host_d : (drive ? mem[address_bus] : ~last);
   initial
   begin
      foreach (mem[i]) mem[i] = ERASED_BYTE;
   end
   always @(posedge clk)
   begin
      last <= data_bus;
      low_cyc <= program_pulse_n ? 0 : low_cyc + 1;
      if (clear)
         hits <= 0;
      else if (!program_pulse_n && low_cyc == PULSE_CYC - 1)
         hits <= hits + 1;
      if (prog_ok && chip_select_n && !output_gate_n && program_pulse_n && host_oe)
      begin
         page[address_bus[1:0]] <= host_d;
         page_base <= address_bus;
      end
      if (fire && chip_select_n)
         for (int i = 0; i < PAGE_BYTES; i++) mem[{page_base[ADDR_W-1:2], i[1:0]}] <= page[i];
      if (fire && !chip_select_n)
         mem[address_bus] <= host_d;
   end
endmodule

// ==== test/prom_programmer_tb.sv ====
`timescale 1ns/1ps
module prom_programmer_tb;
   import prom_prog_pkg::*;
   logic              SYS_CLK = 1'b0;
   logic              RST_N = 1'b0;
   logic              START_PAGE = 1'b0, START_BYTE = 1'b0, START_READ = 1'b0;
   logic [ADDR_W-1:0] REQ_ADDR = '0, ADDRESS_BUS;
   logic [31:0]       REQ_DATA = '0;
   logic [4:0]        need = 5'h01;
   logic              clear = 1'b0;
   logic              BUSY, DONE, FAIL, RANGE_ERR, TARGET_RESET_N;
   logic              CHIP_SELECT_N, OUTPUT_GATE_N, PROGRAM_PULSE_N, DATA_BUS_OE;
   logic [DATA_W-1:0] READ_DATA, DATA_BUS_O, DATA_BUS_I;
   logic [3:0]        TRIES;
   supply_t           SUPPLY_SEL;
   int                errors = 0, n_checks = 0, cycles = 0;
   prom_programmer dut (.SYS_CLK, .RST_N, .START_PAGE, .START_BYTE, .START_READ, .REQ_ADDR,
      .REQ_DATA, .BUSY, .DONE, .FAIL, .RANGE_ERR, .READ_DATA, .TRIES, .TARGET_RESET_N,
      .SUPPLY_SEL, .ADDRESS_BUS, .CHIP_SELECT_N, .OUTPUT_GATE_N, .PROGRAM_PULSE_N,
      .DATA_BUS_O, .DATA_BUS_OE, .DATA_BUS_I);
   prom_device_model part (.clk(SYS_CLK), .reset_n(TARGET_RESET_N), .supply(SUPPLY_SEL),
      .address_bus(ADDRESS_BUS), .chip_select_n(CHIP_SELECT_N), .output_gate_n(OUTPUT_GATE_N),
      .program_pulse_n(PROGRAM_PULSE_N), .host_d(DATA_BUS_O), .host_oe(DATA_BUS_OE),
      .need(need), .clear(clear), .data_bus(DATA_BUS_I));
   always #50 SYS_CLK = ~SYS_CLK;
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Kind 0 read, 1 page, 2 byte; n is how many pulses the part needs
   task automatic run_job(input int kind, input logic [16:0] a, input logic [31:0] d,
                          input logic [4:0] n);
      int i;
      @(posedge SYS_CLK);
      REQ_ADDR <= a;
      REQ_DATA <= d;
      need <= n;
      clear <= 1'b1;
      START_READ <= kind == 0;
      START_PAGE <= kind == 1;
      START_BYTE <= kind == 2;
      @(posedge SYS_CLK);
      {START_READ, START_PAGE, START_BYTE, clear} <= 4'h0;
      @(negedge SYS_CLK);
      for (i = 0; i < 20000 && DONE !== 1'b1 && RANGE_ERR !== 1'b1; i++) @(negedge SYS_CLK);
      if (i >= 20000)
      begin
         errors++;
         wrap_up();
      end
   endtask
   task automatic rd_chk(input logic [16:0] a, input logic [7:0] exp);
      run_job(0, a, 32'h0, 5'h01);
      check(READ_DATA, exp);
   endtask
   task automatic t_idle();
      check({CHIP_SELECT_N, OUTPUT_GATE_N, PROGRAM_PULSE_N, DATA_BUS_OE}, 4'he);
      check({TARGET_RESET_N, BUSY}, 2'b00);
      $display("test idle done");
   endtask
   task automatic t_erased();
      rd_chk(17'h00123, ERASED_BYTE);
      $display("test erased done");
   endtask
   task automatic t_page();
      run_job(1, 17'h00100, 32'h12345678, 5'h01);
      check({FAIL, TRIES}, 5'h01);
      for (int i = 0; i < PAGE_BYTES; i++) rd_chk(17'h00100 + 17'(i), 8'(32'h12345678 >> (8 * i)));
      $display("test page done");
   endtask
   task automatic t_byte();
      run_job(2, 17'h0efff, 32'h0000005a, 5'h03);
      check({FAIL, TRIES}, 5'h03);
      rd_chk(17'h0efff, 8'h5a);
      $display("test byte done");
   endtask
   task automatic t_fail();
      run_job(2, 17'h00200, 32'h000000c3, 5'h1f);
      check(FAIL, 1'b1);
      check(TRIES, MAX_TRIES);
      rd_chk(17'h00200, ERASED_BYTE);
      $display("test fail done");
   endtask
   task automatic t_range();
      run_job(1, 17'h0effd, 32'h11223344, 5'h01);
      check({RANGE_ERR, BUSY, DONE}, 3'b100);
      run_job(2, 17'h0f000, 32'h00000011, 5'h01);
      check({RANGE_ERR, BUSY, DONE}, 3'b100);
      $display("test range done");
   endtask
   // Reset in the middle of a byte pulse must park the pins and leave the cell erased
   task automatic t_reset();
      @(posedge SYS_CLK);
      REQ_ADDR <= 17'h00300;
      REQ_DATA <= 32'h000000a5;
      need <= 5'h01;
      clear <= 1'b1;
      START_BYTE <= 1'b1;
      @(posedge SYS_CLK);
      {START_BYTE, clear} <= 2'b00;
      repeat (20) @(negedge SYS_CLK);
      check(PROGRAM_PULSE_N, 1'b0);
      @(posedge SYS_CLK);
      RST_N <= 1'b0;
      @(negedge SYS_CLK);
      check({CHIP_SELECT_N, OUTPUT_GATE_N, PROGRAM_PULSE_N, DATA_BUS_OE}, 4'he);
      check({BUSY, SUPPLY_SEL}, {1'b0, SUPPLY_OFF});
      repeat (3) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      rd_chk(17'h00300, ERASED_BYTE);
      $display("test reset done");
   endtask
   // Longest job is ten full tries of about a thousand cycles each
   always @(posedge SYS_CLK)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         errors++;
         wrap_up();
      end
   end
   initial
   begin
      repeat (10) @(posedge SYS_CLK);
      RST_N <= 1'b1;
      @(negedge SYS_CLK);
      t_idle();
      t_erased();
      t_page();
      t_byte();
      t_fail();
      t_range();
      t_reset();
      wrap_up();
   end
endmodule
